/* File: design/mac_defines.vh */
`ifndef MAC_DEFINES_VH
`define MAC_DEFINES_VH
// register byte addresses
`define MAC_ADDR_REM2_OFFSET 8'h72
`define MAC_ADDR_CONFIG2 8'h73
`define MAC_ADDR_CONFIG1 8'h40
`define MAC_ADDR_TEST2 8'h7F
`define MAC_ADDR_FAN1_MIN_HI 8'h55
`define MAC_ADDR_REM2_RAW 8'hA0
`define MAC_ADDR_REM2_RESULT 8'hA4
// reset values
`define MAC_RST_REM2_OFFSET 8'h00
`define MAC_RST_CONFIG2 8'h00
`define MAC_RST_CONFIG1 8'h00
`define MAC_RST_TEST2 8'h00
`define MAC_RST_FAN1_MIN_HI 8'h00
// field positions
`define MAC_CFG1_LOCK_BIT 1
`define MAC_CFG2_FAN1_SENSE_BIT 0
`define MAC_CFG2_FAN2_SENSE_BIT 1
`define MAC_CFG2_FAN3_SENSE_BIT 2
`define MAC_CFG2_FAN4_SENSE_BIT 3
`define MAC_CFG2_AVERAGE_BIT 4
`define MAC_CFG2_BYPASS_BIT 5
`define MAC_CFG2_SINGLE_BIT 6
`define MAC_TEST2_EXTCLK_BIT 2
`define MAC_CHSEL_HI 7
`define MAC_CHSEL_LO 5
// channel select codes
`define MAC_CH_2V5 3'h0
`define MAC_CH_CPU 3'h1
`define MAC_CH_3V3 3'h2
`define MAC_CH_5V 3'h3
`define MAC_CH_12V 3'h4
`define MAC_CH_REM1 3'h5
`define MAC_CH_LOCAL 3'h6
`define MAC_CH_REM2 3'h7
`endif

/* File: design/mac_monitor_adc_config.v */
`include "mac_defines.vh"
`default_nettype none
//
// Contract
// - An 8-bit read/write remote 2 offset register exists and clears to zero at reset.
// - The offset is added to the remote 2 reading, one count per degree Celsius.
// - The offset is a signed two's complement value, so negatives lower the result.
// - While the lock bit is set, writes to the offset register are silently dropped.
// - A read/write configuration register 2 sits at 0x73 and resets to zero.
// - With bits 0 to 3 clear, each matching fan is measured as a 3-wire fan.
// - With one of bits 0 to 3 set, that tach input is switched to resistor sensing.
// - Bit 4 enables averaging of temperature and voltage measurements.
// - Bit 5 bypasses the attenuators on the 2.5 V, core, 5 V and 12 V inputs.
// - Bit 6 selects single-channel mode, converting one input continuously.
// - In single-channel mode with test register 2 bit 2 set, conversions start on the ext clock.
// - The single channel comes from bits 7:5 of the fan 1 minimum high byte; 000 is 2.5 V.
// - Bit 7 of configuration register 2 is reserved read/write with no effect.
module mac_monitor_adc_config (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // measurement front end
  input wire [7:0] rem2_raw_temp,
  input wire ext_single_channel_en_a_clk,
  output reg [7:0] rem2_temp_result,
  output reg fan1_resistor_sense_sel,
  output reg fan2_resistor_sense_sel,
  output reg fan3_resistor_sense_sel,
  output reg fan4_resistor_sense_sel,
  output reg measurement_averaging_en,
  output reg input_divider_bypass,
  output reg single_channel_en_a,
  output reg ext_single_channel_en_a_trigger_en,
  output reg single_channel_en_a_start,
  output reg [2:0] single_channel_sel,
  output reg [7:0] channel_onehot
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] rem2_offset_r;
  reg [7:0] config2_r;
  reg [7:0] config1_r;
  reg [7:0] test2_r;
  reg [7:0] fan1_min_hi_r;
  reg [7:0] rem2_offset_nxt;
  reg [7:0] config2_nxt;
  reg [7:0] config1_nxt;
  reg [7:0] test2_nxt;
  reg [7:0] fan1_min_hi_nxt;
  reg ext_clk_d_r;
  reg ack_r;
  reg [7:0] rd_nxt;
  reg [8:0] sum_nxt;
  reg [7:0] res_nxt;
  wire [7:0] onehot_nxt;
  wire bus_req;
  wire take_req;
  wire wr_lo;
  wire locked;
  wire hit_offset;
  wire hit_config2;
  wire hit_config1;
  wire hit_test2;
  wire hit_fan1_min_hi;
  wire single_mode;
  wire ext_trig_mode;
  wire [2:0] chan_code;
  wire single_channel_en_a_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  assign bus_req = avs_read | avs_write;
  assign take_req = bus_req & ~ack_r;
  assign wr_lo = avs_write & avs_byteenable[0] & ack_r;
  assign locked = config1_r[`MAC_CFG1_LOCK_BIT];

  // address hits
  assign hit_offset = (avs_address == `MAC_ADDR_REM2_OFFSET);
  assign hit_config2 = (avs_address == `MAC_ADDR_CONFIG2);
  assign hit_config1 = (avs_address == `MAC_ADDR_CONFIG1);
  assign hit_test2 = (avs_address == `MAC_ADDR_TEST2);
  assign hit_fan1_min_hi = (avs_address == `MAC_ADDR_FAN1_MIN_HI);

  // mode decode
  assign single_mode = config2_r[`MAC_CFG2_SINGLE_BIT];
  assign ext_trig_mode = single_mode & test2_r[`MAC_TEST2_EXTCLK_BIT];
  assign chan_code = fan1_min_hi_r[`MAC_CHSEL_HI:`MAC_CHSEL_LO];
  assign single_channel_en_a_pulse = ext_single_channel_en_a_clk & ~ext_clk_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus: one wait cycle, writes land at the edge that ends the ack cycle after it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take_req;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~take_req;
    end
  end

  // read mux
  always @* begin
    case (avs_address)
      `MAC_ADDR_REM2_OFFSET: rd_nxt = rem2_offset_r;
      `MAC_ADDR_CONFIG2: rd_nxt = config2_r;
      `MAC_ADDR_CONFIG1: rd_nxt = config1_r;
      `MAC_ADDR_TEST2: rd_nxt = test2_r;
      `MAC_ADDR_FAN1_MIN_HI: rd_nxt = fan1_min_hi_r;
      `MAC_ADDR_REM2_RAW: rd_nxt = rem2_raw_temp;
      `MAC_ADDR_REM2_RESULT: rd_nxt = rem2_temp_result;
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data is captured at the edge that ends the wait cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_r) begin
      avs_readdata <= {24'h000000, rd_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  // remote 2 offset, frozen by the lock
  always @* begin
    rem2_offset_nxt = rem2_offset_r;
    if (wr_lo & hit_offset & ~locked) begin
      rem2_offset_nxt = avs_writedata[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rem2_offset_r <= `MAC_RST_REM2_OFFSET;
    end else begin
      rem2_offset_r <= rem2_offset_nxt;
    end
  end

  // configuration 2, frozen by the lock
  always @* begin
    config2_nxt = config2_r;
    if (wr_lo & hit_config2 & ~locked) begin
      config2_nxt = avs_writedata[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config2_r <= `MAC_RST_CONFIG2;
    end else begin
      config2_r <= config2_nxt;
    end
  end

  // configuration 1, lock sticky until reset
  always @* begin
    config1_nxt = config1_r;
    if (wr_lo & hit_config1 & ~locked) begin
      config1_nxt = avs_writedata[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config1_r <= `MAC_RST_CONFIG1;
    end else begin
      config1_r <= config1_nxt;
    end
  end

  // test 2
  always @* begin
    test2_nxt = test2_r;
    if (wr_lo & hit_test2) begin
      test2_nxt = avs_writedata[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      test2_r <= `MAC_RST_TEST2;
    end else begin
      test2_r <= test2_nxt;
    end
  end

  // fan 1 minimum high byte, channel code in its top bits
  always @* begin
    fan1_min_hi_nxt = fan1_min_hi_r;
    if (wr_lo & hit_fan1_min_hi) begin
      fan1_min_hi_nxt = avs_writedata[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan1_min_hi_r <= `MAC_RST_FAN1_MIN_HI;
    end else begin
      fan1_min_hi_r <= fan1_min_hi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset adder, signed, saturating
  always @* begin
    sum_nxt = {rem2_raw_temp[7], rem2_raw_temp} + {rem2_offset_r[7], rem2_offset_r};
    if (sum_nxt[8] != sum_nxt[7]) begin
      res_nxt = sum_nxt[8] ? 8'h80 : 8'h7F;
    end else begin
      res_nxt = sum_nxt[7:0];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rem2_temp_result <= 8'h00;
    end else begin
      rem2_temp_result <= res_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel one-hot
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ch
      assign onehot_nxt[g] = single_mode & ({29'h0, chan_code} == g);
    end
  endgenerate

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_onehot <= 8'h00;
    end else begin
      channel_onehot <= onehot_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fan sensing mode per tach input
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan1_resistor_sense_sel <= 1'b0;
    end else begin
      fan1_resistor_sense_sel <= config2_r[`MAC_CFG2_FAN1_SENSE_BIT];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan2_resistor_sense_sel <= 1'b0;
    end else begin
      fan2_resistor_sense_sel <= config2_r[`MAC_CFG2_FAN2_SENSE_BIT];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan3_resistor_sense_sel <= 1'b0;
    end else begin
      fan3_resistor_sense_sel <= config2_r[`MAC_CFG2_FAN3_SENSE_BIT];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fan4_resistor_sense_sel <= 1'b0;
    end else begin
      fan4_resistor_sense_sel <= config2_r[`MAC_CFG2_FAN4_SENSE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement and divider controls
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      measurement_averaging_en <= 1'b0;
    end else begin
      measurement_averaging_en <= config2_r[`MAC_CFG2_AVERAGE_BIT];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_divider_bypass <= 1'b0;
    end else begin
      input_divider_bypass <= config2_r[`MAC_CFG2_BYPASS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single-channel conversion
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      single_channel_en_a <= 1'b0;
    end else begin
      single_channel_en_a <= single_mode;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      single_channel_sel <= 3'h0;
    end else begin
      single_channel_sel <= chan_code;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_single_channel_en_a_trigger_en <= 1'b0;
    end else begin
      ext_single_channel_en_a_trigger_en <= ext_trig_mode;
    end
  end

  // external clock edge, idle low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_clk_d_r <= 1'b0;
    end else begin
      ext_clk_d_r <= ext_single_channel_en_a_clk;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      single_channel_en_a_start <= 1'b0;
    end else begin
      single_channel_en_a_start <= ext_trig_mode & single_channel_en_a_pulse;
    end
  end

endmodule // mac_monitor_adc_config
`default_nettype wire

/* File: bench/mac_adc_cfg_assertions.sv */
`default_nettype none
module mac_chk (
  // bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // front end
  input wire logic fan1_resistor_sense_sel,
  input wire logic fan2_resistor_sense_sel,
  input wire logic fan3_resistor_sense_sel,
  input wire logic fan4_resistor_sense_sel,
  input wire logic measurement_averaging_en,
  input wire logic single_channel_en_a,
  input wire logic ext_single_channel_en_a_trigger_en,
  input wire logic single_channel_en_a_start,
  input wire logic [2:0] single_channel_sel,
  input wire logic [7:0] channel_onehot
);
  logic [1:0] wh;
  // recent writes
  always_ff @(posedge clk) wh <= {wh[0], avs_write};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_pls; single_channel_en_a_start |=> !single_channel_en_a_start; endproperty
  a_pls: assert property (p_pls) else $error("long start");
  property p_trg; ext_single_channel_en_a_trigger_en |-> single_channel_en_a; endproperty
  a_trg: assert property (p_trg) else $error("trig");
  property p_oh;
    channel_onehot != 8'h00 |-> channel_onehot == 8'h01 << single_channel_sel;
  endproperty
  a_oh: assert property (p_oh) else $error("onehot");
  property p_fan;
    $changed({fan4_resistor_sense_sel, fan3_resistor_sense_sel,
      fan2_resistor_sense_sel, fan1_resistor_sense_sel}) |-> |wh;
  endproperty
  a_fan: assert property (p_fan) else $error("fan sel");
  property p_mean; $changed(measurement_averaging_en) |-> |wh; endproperty
  a_mean: assert property (p_mean) else $error("averaging");
  property p_sce; $changed(single_channel_en_a) |-> |wh; endproperty
  a_sce: assert property (p_sce) else $error("single");
endmodule // mac_chk
bind mac_monitor_adc_config mac_chk u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .fan1_resistor_sense_sel(fan1_resistor_sense_sel),
  .fan2_resistor_sense_sel(fan2_resistor_sense_sel),
  .fan3_resistor_sense_sel(fan3_resistor_sense_sel),
  .fan4_resistor_sense_sel(fan4_resistor_sense_sel),
  .measurement_averaging_en(measurement_averaging_en),
  .single_channel_en_a(single_channel_en_a),
  .ext_single_channel_en_a_trigger_en(ext_single_channel_en_a_trigger_en),
  .single_channel_en_a_start(single_channel_en_a_start),
  .single_channel_sel(single_channel_sel),
  .channel_onehot(channel_onehot)
);
`default_nettype wire

/* File: bench/test_monitor_adc_config.sv */
`default_nettype none
module test_monitor_adc_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, ext_single_channel_en_a_clk = 0;
  logic [7:0] avs_address = 0, rem2_raw_temp = 0, v, o, rem2_temp_result, channel_onehot;
  logic [31:0] avs_writedata = 0, avs_readdata, q[$];
  logic [3:0] avs_byteenable = 4'hF;
  logic fan1_resistor_sense_sel, fan2_resistor_sense_sel;
  logic fan3_resistor_sense_sel, fan4_resistor_sense_sel;
  logic [7:0] t;
  logic avs_waitrequest, measurement_averaging_en, input_divider_bypass, single_channel_en_a;
  logic ext_single_channel_en_a_trigger_en, single_channel_en_a_start;
  logic [2:0] single_channel_sel, n;
  logic signed [8:0] s;
  int errors = 0, cmp_count = 0, cyc = 0, seed = 32'h639AB0C4;
  always #25 clk = ~clk;
  mac_monitor_adc_config i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rem2_raw_temp(rem2_raw_temp),
    .ext_single_channel_en_a_clk(ext_single_channel_en_a_clk),
    .rem2_temp_result(rem2_temp_result),
    .fan1_resistor_sense_sel(fan1_resistor_sense_sel),
    .fan2_resistor_sense_sel(fan2_resistor_sense_sel),
    .fan3_resistor_sense_sel(fan3_resistor_sense_sel),
    .fan4_resistor_sense_sel(fan4_resistor_sense_sel),
    .measurement_averaging_en(measurement_averaging_en),
    .input_divider_bypass(input_divider_bypass),
    .single_channel_en_a(single_channel_en_a),
    .ext_single_channel_en_a_trigger_en(ext_single_channel_en_a_trigger_en),
    .single_channel_en_a_start(single_channel_en_a_start),
    .single_channel_sel(single_channel_sel),
    .channel_onehot(channel_onehot)
  );
  task report_and_stop;
    $display("errors %0d checks %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(string t, logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", t, e, g);
    end
  endtask
  // read expects d, write stores d
  task bus(logic r, logic [7:0] a, d);
    if (r) q.push_back({24'h0, d});
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    {avs_read, avs_write} <= {r, !r};
    do @(posedge clk); while (avs_waitrequest !== 1'h0);
    {avs_read, avs_write} <= 2'h0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      report_and_stop;
    end else if (avs_read && avs_waitrequest === 1'h0)
      chk("rdata", q.pop_front(), avs_readdata);
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    bus(1, 8'h72, 8'h00);
    bus(1, 8'h73, 8'h00);
    bus(0, 8'h10, 8'h5A);
    bus(1, 8'h10, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      bus(0, 8'h73, v);
      bus(1, 8'h73, v);
      repeat (3) @(posedge clk);
      chk("cfg", v[6:0], {single_channel_en_a, input_divider_bypass,
        measurement_averaging_en, fan4_resistor_sense_sel, fan3_resistor_sense_sel,
        fan2_resistor_sense_sel, fan1_resistor_sense_sel});
    end
    avs_byteenable <= 4'hE;
    bus(0, 8'h73, ~v);
    avs_byteenable <= 4'hF;
    bus(1, 8'h73, v);
    for (int i = 0; i < 8; i++) begin
      {v, o} = 16'($random(seed));
      if (i < 2) {v, o} = i ? 16'h85F0 : 16'h7A10;
      rem2_raw_temp <= v;
      bus(0, 8'h72, o);
      repeat (3) @(posedge clk);
      s = $signed({v[7], v}) + $signed({o[7], o});
      t = s > 127 ? 8'h7F : s < -128 ? 8'h80 : s[7:0];
      chk("temp", t, rem2_temp_result);
      bus(1, 8'hA0, v);
      bus(1, 8'hA4, t);
    end
    bus(0, 8'h73, 8'h40);
    bus(0, 8'h7F, 8'h04);
    for (int i = 0; i < 8; i++) begin
      bus(0, 8'h55, {i[2:0], 5'h00});
      repeat (3) @(posedge clk);
      chk("onehot", 8'h01 << i, channel_onehot);
      chk("sel", i, single_channel_sel);
    end
    chk("trig", 1, ext_single_channel_en_a_trigger_en);
    for (int k = 0; k < 2; k++) begin
      if (k) bus(0, 8'h7F, 8'h00);
      ext_single_channel_en_a_clk <= 1'h1;
      n = 0;
      repeat (8) @(posedge clk) n += single_channel_en_a_start;
      ext_single_channel_en_a_clk <= 1'h0;
      chk("start", !k, n);
    end
    bus(0, 8'h72, 8'h11);
    bus(0, 8'h40, 8'h02);
    bus(0, 8'h72, 8'h22);
    bus(1, 8'h72, 8'h11);
    report_and_stop;
  end
endmodule // test_monitor_adc_config
`default_nettype wire
